// [lgcc_group.v]
// group of eight logic cells with four shared control lines,
// carry and cascade chains, and registered cell outputs.
// assumes data, internal control and chain inputs come from logic
// on CLK_SYS_I; dedicated, global and I/O control pins are async.
`timescale 1ns/1ns
`default_nettype none
`include "lgcc_consts.vh"

// Overview of operation
// - four invertible control lines shared by eight cells
// - two lines clock, two clear or preset
// - clock and clear/preset lines pick their sources
// - four-input table computes any function
// - register with clock enable, carry, cascade links
// - register acts as D, T, JK, SR
// - combinational use bypasses the register
// - two independently chosen cell outputs
// - carry-in feeds table and next carry stage
// - chains link all cells and row groups
// - long carry skips to group two on
// - carry chain restarts past the memory block
// - n-bit adder takes n+1 cells
// - cascade combines by AND, OR by inversion
// - n cascaded cells take 4n inputs
// - long cascade skips to group two on
// - cascade chain restarts past the memory block
// - normal, arithmetic, up/down, clearable counter modes
// - seven function inputs steered by mode
// - three register control inputs per cell
// - clock enable in all modes, from first input
// - normal mode picks carry or third input
// - arithmetic mode: sum table and carry table
// - up/down counter with direction and load selector
// - clearable counter ANDs load result with clear
module lgcc_group
#(
	parameter integer NUM_CELLS   = `LGCC_GROUP_CELLS,
	parameter integer GROUP_INDEX = 0,
	parameter integer RAM_GROUP   = 18
)
(
	// clock and reset
	input  wire                   CLK_SYS_I,
	input  wire                   RESET_I,
	// control line sources
	input  wire [1:0]             DED_CLK_I,
	input  wire [3:0]             GLOBAL_I,
	input  wire [3:0]             IO_CTRL_I,
	input  wire [3:0]             INT_CTRL_I,
	// control line configuration
	input  wire [3:0]             LINE_SRC_CLK_I,
	input  wire [3:0]             LINE_SRC_CP_I,
	input  wire [3:0]             LINE_INV_I,
	// per cell configuration
	input  wire [NUM_CELLS*16-1:0] LUT_CFG_I,
	input  wire [NUM_CELLS*2-1:0] MODE_I,
	input  wire [NUM_CELLS*2-1:0] FF_TYPE_I,
	input  wire [NUM_CELLS-1:0]   CIN_SEL_I,
	input  wire [NUM_CELLS-1:0]   CE_USE_I,
	input  wire [NUM_CELLS-1:0]   REG_SRC_I,
	input  wire [NUM_CELLS-1:0]   CLK_SEL_I,
	input  wire [NUM_CELLS*2-1:0] CLR_SEL_I,
	input  wire [NUM_CELLS*2-1:0] PRE_SEL_I,
	input  wire [NUM_CELLS-1:0]   LOCAL_SEL_I,
	input  wire [NUM_CELLS-1:0]   ROW_SEL_I,
	// cell data from local routing
	input  wire [NUM_CELLS*4-1:0] DATA_I,
	// chains from the group two positions back
	input  wire                   CARRY_I,
	input  wire                   CASC_I,
	// cell outputs
	output reg  [NUM_CELLS-1:0]   LOCAL_O,
	output reg  [NUM_CELLS-1:0]   ROW_O,
	// chains toward the group two positions on
	output reg                    CARRY_O,
	output reg                    CASC_O,
	// group state
	output reg  [3:0]             LINE_STATE_O,
	output reg  [NUM_CELLS-1:0]   CELL_CARRY_O
);

	localparam integer NUM_PINS = 10;

	// chain is fresh at the row start and on the far side of the memory block
	localparam FRESH_CHAIN = (GROUP_INDEX < 2) || (GROUP_INDEX == RAM_GROUP) ||
		(GROUP_INDEX == RAM_GROUP + 1);

	wire [NUM_PINS-1:0]  pins;
	reg  [NUM_PINS-1:0]  sync1_q;
	reg  [NUM_PINS-1:0]  sync2_q;
	wire [1:0]           ded_s;
	wire [3:0]           glob_s;
	wire [3:0]           io_s;

	wire [3:0]           line_raw;
	wire [3:0]           line_val;
	reg  [1:0]           clk_prev_q;
	reg                  edge_armed_q;
	wire [1:0]           clk_tick;

	wire [NUM_CELLS:0]   carry;
	wire [NUM_CELLS:0]   casc;
	wire [NUM_CELLS-1:0] comb;
	wire [NUM_CELLS-1:0] regq;
	wire [NUM_CELLS-1:0] local_d;
	wire [NUM_CELLS-1:0] row_d;
	wire                 carry_start;
	wire                 casc_start;

	genvar gi;

	// two-stage synchronisers on pin-driven control sources
	assign pins = {IO_CTRL_I, GLOBAL_I, DED_CLK_I};

	always @(posedge CLK_SYS_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			sync1_q <= {NUM_PINS{1'h0}};
			sync2_q <= {NUM_PINS{1'h0}};
		end
		else
		begin
			sync1_q <= pins;
			sync2_q <= sync1_q;
		end
	end

	assign ded_s  = sync2_q[1:0];
	assign glob_s = sync2_q[5:2];
	assign io_s   = sync2_q[9:6];

	// control line source selection, one line per iteration
	generate
		for (gi = 0; gi < `LGCC_CTRL_LINES; gi = gi + 1)
		begin : g_line
			if (gi < `LGCC_CLK_LINES)
			begin : g_clk
				reg src_bit;

				always @*
				begin
					case (LINE_SRC_CLK_I[gi*2 +: 2])
						`LGCC_CSRC_DEDICATED: src_bit = ded_s[gi];
						`LGCC_CSRC_GLOBAL:    src_bit = glob_s[gi];
						`LGCC_CSRC_IO:        src_bit = io_s[gi];
						default:              src_bit = INT_CTRL_I[gi];
					endcase
				end

				assign line_raw[gi] = src_bit;
			end
			else
			begin : g_cp
				reg src_bit;

				always @*
				begin
					case (LINE_SRC_CP_I[(gi-2)*2 +: 2])
						`LGCC_PSRC_GLOBAL: src_bit = glob_s[gi];
						`LGCC_PSRC_IO:     src_bit = io_s[gi];
						default:           src_bit = INT_CTRL_I[gi];
					endcase
				end

				assign line_raw[gi] = src_bit;
			end
			assign line_val[gi] = line_raw[gi] ^ LINE_INV_I[gi];
		end
	endgenerate

	// group clocks act on their rising edge as seen by the system clock
	// an inverted line idles high; the first edge after reset only
	// loads the history, so no false tick follows reset
	always @(posedge CLK_SYS_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			clk_prev_q   <= 2'h0;
			edge_armed_q <= 1'h0;
		end
		else
		begin
			clk_prev_q   <= line_val[1:0];
			edge_armed_q <= 1'h1;
		end
	end

	assign clk_tick = line_val[1:0] & ~clk_prev_q & {2{edge_armed_q}};

	// chain entry; a fresh chain starts with carry 0 and cascade 1
	assign carry_start = FRESH_CHAIN ? 1'h0 : CARRY_I;
	assign casc_start  = FRESH_CHAIN ? 1'h1 : CASC_I;
	assign carry[0]    = carry_start;
	assign casc[0]     = casc_start;

	// the eight cells, chained low to high
	generate
		for (gi = 0; gi < NUM_CELLS; gi = gi + 1)
		begin : g_cell
			wire [1:0] clr_sel;
			wire [1:0] pre_sel;
			reg        clr;
			reg        pre;
			wire       tick;

			assign clr_sel = CLR_SEL_I[gi*2 +: 2];
			assign pre_sel = PRE_SEL_I[gi*2 +: 2];
			assign tick    = clk_tick[CLK_SEL_I[gi]];

			always @*
			begin
				case (clr_sel)
					`LGCC_CP_LINE2: clr = line_val[2];
					`LGCC_CP_LINE3: clr = line_val[3];
					default:        clr = 1'h0;
				endcase
			end

			always @*
			begin
				case (pre_sel)
					`LGCC_CP_LINE2: pre = line_val[2];
					`LGCC_CP_LINE3: pre = line_val[3];
					default:        pre = 1'h0;
				endcase
			end

			// seven function inputs: four data, feedback, carry, cascade
			lgcc_cell u_cell
			(
				.clk_i     (CLK_SYS_I),
				.rst_i     (RESET_I),
				.lut_cfg_i (LUT_CFG_I[gi*16 +: 16]),
				.mode_i    (MODE_I[gi*2 +: 2]),
				.ff_type_i (FF_TYPE_I[gi*2 +: 2]),
				.cin_sel_i (CIN_SEL_I[gi]),
				.ce_use_i  (CE_USE_I[gi]),
				.reg_src_i (REG_SRC_I[gi]),
				.data_i    (DATA_I[gi*4 +: 4]),
				.carry_i   (carry[gi]),
				.casc_i    (casc[gi]),
				.tick_i    (tick),
				.clr_i     (clr),
				.pre_i     (pre),
				.carry_o   (carry[gi+1]),
				.casc_o    (casc[gi+1]),
				.comb_o    (comb[gi]),
				.reg_o     (regq[gi])
			);

			// independent choice of the two outputs
			assign local_d[gi] = (LOCAL_SEL_I[gi] == `LGCC_OUT_REG) ? regq[gi] : comb[gi];
			assign row_d[gi]   = (ROW_SEL_I[gi] == `LGCC_OUT_REG) ? regq[gi] : comb[gi];
		end
	endgenerate

	// all cell outputs in one process, so each port has one driver
	always @(posedge CLK_SYS_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			LOCAL_O      <= {NUM_CELLS{1'h0}};
			ROW_O        <= {NUM_CELLS{1'h0}};
			CELL_CARRY_O <= {NUM_CELLS{1'h0}};
		end
		else
		begin
			LOCAL_O      <= local_d;
			ROW_O        <= row_d;
			CELL_CARRY_O <= carry[NUM_CELLS-1:0];
		end
	end

	// chain outputs toward the group two positions on
	always @(posedge CLK_SYS_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			CARRY_O      <= 1'h0;
			CASC_O       <= 1'h1;
			LINE_STATE_O <= 4'h0;
		end
		else
		begin
			CARRY_O      <= carry[NUM_CELLS];
			CASC_O       <= casc[NUM_CELLS];
			LINE_STATE_O <= line_val;
		end
	end

endmodule // lgcc_group

`default_nettype wire

// [lgcc_consts.vh]
// constants for the logic cell group: mode codes, storage types,
// control line source codes, cell output selects and table sizes.
// included by the cell and the cell group; definitions only.
`ifndef LGCC_CONSTS_VH
`define LGCC_CONSTS_VH

// cell operating modes
`define LGCC_MODE_NORMAL    2'h0
`define LGCC_MODE_ARITH     2'h1
`define LGCC_MODE_UPDN      2'h2
`define LGCC_MODE_CLRCNT    2'h3

// storage element types
`define LGCC_FF_D           2'h0
`define LGCC_FF_T           2'h1
`define LGCC_FF_JK          2'h2
`define LGCC_FF_SR          2'h3

// clock line sources (lines 0 and 1)
`define LGCC_CSRC_DEDICATED 2'h0
`define LGCC_CSRC_GLOBAL    2'h1
`define LGCC_CSRC_IO        2'h2
`define LGCC_CSRC_INTERNAL  2'h3

// clear/preset line sources (lines 2 and 3)
`define LGCC_PSRC_GLOBAL    2'h0
`define LGCC_PSRC_IO        2'h1
`define LGCC_PSRC_INTERNAL  2'h2

// per cell clear or preset line choice
`define LGCC_CP_NONE        2'h0
`define LGCC_CP_LINE2       2'h1
`define LGCC_CP_LINE3       2'h2

// cell output source
`define LGCC_OUT_COMB       1'h0
`define LGCC_OUT_REG        1'h1

// table and group sizes, register reset value
`define LGCC_LUT_ENTRIES    16
`define LGCC_LUT_INPUTS     4
`define LGCC_GROUP_CELLS    8
`define LGCC_CTRL_LINES     4
`define LGCC_CLK_LINES      2
`define LGCC_RESET_Q        1'h0

`endif

// [lgcc_cell.v]
// one logic cell: sixteen entry table, mode steering, chains, register.
// assumes config inputs are static and tick/clear/preset come
// from the group on the same clock.
`timescale 1ns/1ns
`default_nettype none
`include "lgcc_consts.vh"

module lgcc_cell
(
	// clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// configuration
	input  wire [15:0] lut_cfg_i,
	input  wire [1:0]  mode_i,
	input  wire [1:0]  ff_type_i,
	input  wire        cin_sel_i,
	input  wire        ce_use_i,
	input  wire        reg_src_i,
	// function inputs
	input  wire [3:0]  data_i,
	input  wire        carry_i,
	input  wire        casc_i,
	// register controls
	input  wire        tick_i,
	input  wire        clr_i,
	input  wire        pre_i,
	// results
	output reg         carry_o,
	output wire        casc_o,
	output reg         comb_o,
	output wire        reg_o
);

	reg        q_q;
	reg        q_d;
	reg        lut;
	reg        din;
	wire       ce;
	wire [3:0] idx_norm;

	assign idx_norm = {data_i[3], (cin_sel_i ? carry_i : data_i[2]), data_i[1], data_i[0]};
	assign ce       = ce_use_i ? data_i[0] : 1'h1;
	assign casc_o   = comb_o;
	assign reg_o    = q_q;

	always @*
	begin
		lut     = 1'h0;
		carry_o = carry_i;
		case (mode_i)
			`LGCC_MODE_NORMAL:
			begin
				lut = lut_cfg_i[idx_norm];
			end
			`LGCC_MODE_ARITH:
			begin
				lut     = lut_cfg_i[{1'h0, carry_i, data_i[1], data_i[0]}];
				carry_o = lut_cfg_i[{1'h1, carry_i, data_i[1], data_i[0]}];
			end
			default:
			begin
				lut     = lut_cfg_i[{1'h0, carry_i, data_i[1], q_q}];
				carry_o = lut_cfg_i[{1'h1, carry_i, data_i[1], q_q}];
			end
		endcase
		// cascade-in is the sync clear in clearable mode, so it is not combined
		comb_o = (mode_i == `LGCC_MODE_CLRCNT) ? lut : (lut & casc_i);
	end

	always @*
	begin
		din = (reg_src_i == `LGCC_OUT_REG) ? data_i[3] : comb_o;
		q_d = din;
		case (mode_i)
			`LGCC_MODE_UPDN:
				q_d = data_i[2] ? data_i[3] : lut;
			`LGCC_MODE_CLRCNT:
				q_d = (data_i[2] ? data_i[3] : lut) & casc_i;
			default:
			begin
				case (ff_type_i)
					`LGCC_FF_T:  q_d = q_q ^ din;
					`LGCC_FF_JK: q_d = (din & ~q_q) | (~data_i[1] & q_q);
					`LGCC_FF_SR: q_d = din | (~data_i[1] & q_q);
					default:     q_d = din;
				endcase
			end
		endcase
	end

	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			q_q <= `LGCC_RESET_Q;
		else if (clr_i)
			q_q <= 1'h0;
		else if (pre_i)
			q_q <= 1'h1;
		else if (tick_i && ce)
			q_q <= q_d;
	end

endmodule // lgcc_cell

`default_nettype wire

// [lgcc_chk_assertions.sv]
// port checker for the logic cell group, bound to lgcc_group
// assumes a group past the row start and not just past the memory block, so chains come from CARRY_I/CASC_I
`timescale 1ns/1ns
`default_nettype none
module lgcc_chk
#(
	parameter integer NUM_CELLS = 8
)
(
	// clock and reset
	input wire logic			CLK_SYS_I,
	input wire logic			RESET_I,
	// inputs
	input wire logic [3:0]			INT_CTRL_I,
	input wire logic [3:0]			LINE_SRC_CLK_I,
	input wire logic [3:0]			LINE_INV_I,
	input wire logic [NUM_CELLS*2-1:0]	MODE_I,
	input wire logic [NUM_CELLS-1:0]	CE_USE_I,
	input wire logic [NUM_CELLS*2-1:0]	CLR_SEL_I,
	input wire logic [NUM_CELLS*2-1:0]	PRE_SEL_I,
	input wire logic [NUM_CELLS-1:0]	LOCAL_SEL_I,
	input wire logic [NUM_CELLS-1:0]	ROW_SEL_I,
	input wire logic [NUM_CELLS*4-1:0]	DATA_I,
	input wire logic			CARRY_I,
	input wire logic			CASC_I,
	// outputs
	input wire logic [NUM_CELLS-1:0]	LOCAL_O,
	input wire logic [NUM_CELLS-1:0]	ROW_O,
	input wire logic			CARRY_O,
	input wire logic			CASC_O,
	input wire logic [3:0]			LINE_STATE_O,
	input wire logic [NUM_CELLS-1:0]	CELL_CARRY_O
);
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (RESET_I);
	wire nrm = (MODE_I == {2*NUM_CELLS{1'b0}}) && !RESET_I;

	a_line_inv: assert property (LINE_SRC_CLK_I[1:0] == 2'h3 |=>
		LINE_STATE_O[0] == ($past(INT_CTRL_I[0]) ^ $past(LINE_INV_I[0]))) else $error("line 0 wrong");
	a_carry_entry: assert property ($past(!RESET_I) |-> CELL_CARRY_O[0] == $past(CARRY_I))
		else $error("carry entry wrong");
	a_carry_pass: assert property ($past(nrm) |-> CELL_CARRY_O == {NUM_CELLS{CELL_CARRY_O[0]}})
		else $error("carry pass wrong");
	a_carry_out: assert property ($past(nrm) |-> CARRY_O == CELL_CARRY_O[NUM_CELLS-1])
		else $error("carry out wrong");
	a_casc_and: assert property ($past(nrm && LOCAL_SEL_I == 0) |->
		(LOCAL_O & ~{LOCAL_O[NUM_CELLS-2:0], $past(CASC_I)}) == 0) else $error("cascade and wrong");
	a_casc_out: assert property ($past(nrm && LOCAL_SEL_I == 0) |-> CASC_O == LOCAL_O[NUM_CELLS-1])
		else $error("cascade out wrong");
	a_out_twin: assert property ($past(LOCAL_SEL_I == ROW_SEL_I && !RESET_I) |-> LOCAL_O == ROW_O)
		else $error("outputs differ");
	a_clr_wins: assert property ((CLR_SEL_I[1:0] == 2'h1 && LINE_STATE_O[2] && ROW_SEL_I[0])[*3]
		|-> !ROW_O[0]) else $error("clear missed");
	a_pre_set: assert property ((CLR_SEL_I[1:0] == 2'h0 && PRE_SEL_I[1:0] == 2'h2 && LINE_STATE_O[3]
		&& ROW_SEL_I[0])[*3] |-> ROW_O[0]) else $error("preset missed");
	a_ce_hold: assert property ((CE_USE_I[0] && !DATA_I[0] && CLR_SEL_I[1:0] == 0
		&& PRE_SEL_I[1:0] == 0 && ROW_SEL_I[0])[*3] |-> $stable(ROW_O[0])) else $error("enable ignored");
endmodule // lgcc_chk
bind lgcc_group lgcc_chk #(.NUM_CELLS(NUM_CELLS)) u_chk (.CLK_SYS_I(CLK_SYS_I), .RESET_I(RESET_I),
	.INT_CTRL_I(INT_CTRL_I), .LINE_SRC_CLK_I(LINE_SRC_CLK_I), .LINE_INV_I(LINE_INV_I), .MODE_I(MODE_I),
	.CE_USE_I(CE_USE_I), .CLR_SEL_I(CLR_SEL_I), .PRE_SEL_I(PRE_SEL_I), .LOCAL_SEL_I(LOCAL_SEL_I),
	.ROW_SEL_I(ROW_SEL_I), .DATA_I(DATA_I), .CARRY_I(CARRY_I), .CASC_I(CASC_I), .LOCAL_O(LOCAL_O),
	.ROW_O(ROW_O), .CARRY_O(CARRY_O), .CASC_O(CASC_O), .LINE_STATE_O(LINE_STATE_O),
	.CELL_CARRY_O(CELL_CARRY_O));
`default_nettype wire

// [lgcc_nbr.sv]
// neighbour model: upstream group chain flops and internal control lines
// runs on the system clock; a tick request gives a one-cycle pulse
`timescale 1ns/1ns
`default_nettype none
module lgcc_nbr
(
	// clock and reset
	input  wire logic	clk_i,
	input  wire logic	rst_i,
	// requests
	input  wire logic [3:0]	line_d_i,
	input  wire logic	tick_i,
	input  wire logic	carry_d_i,
	input  wire logic	casc_d_i,
	// to the group
	output var  logic [3:0]	line_o,
	output var  logic	carry_o,
	output var  logic	casc_o
);
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			{line_o, carry_o, casc_o} <= 6'h01;
		else
		begin
			line_o <= {line_d_i[3:1], line_d_i[0] | (tick_i & ~line_o[0])};
			carry_o <= carry_d_i;
			casc_o <= casc_d_i;
		end
	end
endmodule // lgcc_nbr
`default_nettype wire

// [lgcc_group_bench.sv]
// self-checking bench for the logic cell group, index 2 in its row
// inputs change 5 ns after the rising clock edge
`timescale 1ns/1ns
`default_nettype none
module lgcc_group_bench;
	logic		clk, rst, tick, cy_d, cs_d;
	logic [1:0]	ded, c;
	logic [3:0]	glob, io, sclk, scp, inv, ld;
	logic [127:0]	lut;
	logic [15:0]	mode, fft, clrs, pres;
	logic [7:0]	cins, ceu, rsrc, csel, lsel, rsel, cv;
	logic [31:0]	data;
	logic [6:0]	a, b;
	wire logic	cy, cs, co, so;
	wire logic [3:0]	ictl, ls;
	wire logic [7:0]	lo, ro, cc;
	integer		n_errors, n_tests, i, k, p;
	logic [5:0]	tbl [0:10] = '{6'h0b, 6'h01, 6'h02, 6'h1b, 6'h1a, 6'h2b, 6'h2e, 6'h22, 6'h2f, 6'h36, 6'h3f};
	logic [14:0]	vec [0:2] = '{{7'h7f, 7'h01, 1'h0}, {7'h55, 7'h2a, 1'h1}, {7'h40, 7'h40, 1'h1}};
	logic [6:0]	cnt [0:5] = '{7'h20, 7'h26, 7'h2d, 7'h3b, 7'h58, 7'h63};

	lgcc_nbr u_nbr (.clk_i(clk), .rst_i(rst), .line_d_i(ld), .tick_i(tick), .carry_d_i(cy_d),
		.casc_d_i(cs_d), .line_o(ictl), .carry_o(cy), .casc_o(cs));
	lgcc_group #(.GROUP_INDEX(2)) u_dut (.CLK_SYS_I(clk), .RESET_I(rst), .DED_CLK_I(ded), .GLOBAL_I(glob),
		.IO_CTRL_I(io), .INT_CTRL_I(ictl), .LINE_SRC_CLK_I(sclk), .LINE_SRC_CP_I(scp), .LINE_INV_I(inv),
		.LUT_CFG_I(lut), .MODE_I(mode), .FF_TYPE_I(fft), .CIN_SEL_I(cins), .CE_USE_I(ceu), .REG_SRC_I(rsrc),
		.CLK_SEL_I(csel), .CLR_SEL_I(clrs), .PRE_SEL_I(pres), .LOCAL_SEL_I(lsel), .ROW_SEL_I(rsel),
		.DATA_I(data), .CARRY_I(cy), .CASC_I(cs), .LOCAL_O(lo), .ROW_O(ro), .CARRY_O(co), .CASC_O(so),
		.LINE_STATE_O(ls), .CELL_CARRY_O(cc));

	task step(input integer n);
		repeat (n) @(posedge clk);
		#5;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task summarize;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial
	begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	initial
	begin
		#1000000;
		n_errors++;
		summarize;
	end
	initial
	begin
		{ded, glob, io, sclk, scp, inv, ld, tick, cy_d, lut, mode, fft, clrs, pres} = '0;
		{cins, ceu, rsrc, csel, lsel, rsel, data} = '0;
		{n_errors, n_tests, cs_d, rst} = '1;
		{n_errors, n_tests} = '0;
		step(16);
		rst = 0;
		step(2);
		// each source of clock line 0 and clear line 2
		for (k = 0; k < 4; k++)
		begin
			c = (k == 3) ? 2'h2 : k[1:0];
			{sclk, scp, inv} = {2'h0, k[1:0], 2'h0, c, 4'h0};
			ded = {1'b0, k == 0};
			glob = {1'b0, c == 0, 1'b0, k == 1};
			io = {1'b0, c == 1, 1'b0, k == 2};
			ld = {1'b0, c == 2, 1'b0, k == 3};
			step(6);
			chk(ls & 4'h5, 4'h5);
			inv = 4'h5;
			step(6);
			chk(ls & 4'h5, 4'h0);
		end
		{ded, glob, io, ld, inv, sclk, scp} = {18'h0, 8'hfa};
		// cell 0 register: storage types, enable, packing
		{ceu, rsrc, rsel} = 24'h010101;
		for (i = 0; i < 11; i++)
		begin
			fft[1:0] = tbl[i][5:4];
			data[3:0] = {tbl[i][3], 1'b0, tbl[i][2:1]};
			tick = 1;
			step(1);
			tick = 0;
			step(5);
			chk({lo[0], ro[0]}, {1'b0, tbl[i][0]});
		end
		{clrs[1:0], pres[1:0], ld} = 8'h6c;
		step(5);
		chk(ro[0], 1'b0);
		clrs = 0;
		step(5);
		chk(ro[0], 1'b1);
		{ld, pres, ceu, rsrc, rsel} = '0;
		// 7-bit adder in cells 0..6, carry-out lands in cell 7
		mode = 16'h1555;
		lut = {8{16'he896}};
		for (i = 0; i < 3; i++)
		begin
			{a, b, cy_d} = vec[i];
			for (k = 0; k < 7; k++)
				data[4*k +: 4] = {2'h0, b[k], a[k]};
			step(4);
			cv[0] = cy_d;
			for (k = 0; k < 7; k++)
				cv[k+1] = a[k] & b[k] | cv[k] & (a[k] ^ b[k]);
			chk({co, cc}, {cv[7], cv});
			chk(lo[0], a[0] ^ b[0] ^ cv[0]);
		end
		// wide and, then or through inverted tables
		{mode, cy_d} = '0;
		for (p = 0; p < 2; p++)
		begin
			lut = {8{p ? 16'h0001 : 16'h8000}};
			for (k = 0; k < 9; k++)
			begin
				data = p ? 32'h0 : 32'hffffffff;
				if (k < 8)
					data[4*k + k%4] = p[0];
				step(4);
				chk({so, lo}, k == 8 ? 9'h1ff : {1'b0, 8'hff >> (8 - k)});
			end
		end
		// cell 0 as up/down, then clearable, counter bit; carry-in held high
		{lut[15:0], rsel[0], cy_d} = {16'h605a, 2'h3};
		for (i = 0; i < 6; i++)
		begin
			{mode[1:0], cs_d, data[3:1]} = {1'b1, cnt[i][6:2]};
			tick = 1;
			step(1);
			tick = 0;
			step(5);
			chk({ro[0], cc[1]}, cnt[i][1:0]);
		end
		summarize;
	end
endmodule // lgcc_group_bench
`default_nettype wire
